// ===== sirq_checker.sv
`timescale 1ns/1ps
module sirq_checker #(
  parameter logic [31:0] USED_MASK = sirq_pkg::DEV_USED_MASK
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hostBusClock,
  input wire logic devOut,
  input wire logic devOeN,
  input wire logic hostOut,
  input wire logic hostOeN,
  input wire logic serialLine
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] clkSync;  // Link clock sync and edge flop
    logic       hostHigh; // Host high, one cycle ago
    logic       inCycle;  // Between start end and stop end
    logic [7:0] linkIdx;  // Link clocks since start end
    logic [4:0] devCnt;   // Device low run
    logic [7:0] hostCnt;  // Host low run
    logic [7:0] lineCnt;  // Line low run
  } sirq_chk_state_type;

  sirq_chk_state_type state_q;  // Registered helper state
  sirq_chk_state_type state_d;  // Next helper state
  logic               devLow;   // Device pulls low
  logic               devHigh;  // Device drives high
  logic               hostLow;  // Host pulls low
  logic               hostHigh; // Host drives high
  logic               linkRise; // Seen link clock rise
  logic               edgeHigh; // Host high begins

  assign devLow   = !devOeN && !devOut;
  assign devHigh  = !devOeN && devOut;
  assign hostLow  = !hostOeN && !hostOut;
  assign hostHigh = !hostOeN && hostOut;
  assign linkRise = state_q.clkSync[1] && !state_q.clkSync[2];
  assign edgeHigh = hostHigh && !state_q.hostHigh;

  // Counts runs and link clocks, tracks the cycle
  always_comb begin
    state_d = state_q;
    state_d.clkSync = {state_q.clkSync[1:0], hostBusClock};
    state_d.hostHigh = hostHigh;
    if (edgeHigh) begin
      // Start end opens, stop end closes
      state_d.inCycle = !state_q.inCycle;
      state_d.linkIdx = 8'h00;
    end else if (linkRise && state_q.linkIdx != 8'hff) begin
      state_d.linkIdx = state_q.linkIdx + 8'h01;
    end
    state_d.devCnt = !devLow ? 5'h00 :
      (state_q.devCnt == 5'h1f ? 5'h1f : state_q.devCnt + 5'h01);
    state_d.hostCnt = !hostLow ? 8'h00 :
      (state_q.hostCnt == 8'hff ? 8'hff : state_q.hostCnt + 8'h01);
    state_d.lineCnt = serialLine ? 8'h00 :
      (state_q.lineCnt == 8'hff ? 8'hff : state_q.lineCnt + 8'h01);
  end

  // Registers the helper state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_NO_OVERLAP: assert property (
    !(!devOeN && !hostOeN)) else $error("both ends drive the line");
  AST_DEV_LOW_MAX: assert property (
    state_q.devCnt <= 5'h11) else $error("device low too long");
  AST_DEV_LOW_WIDTH: assert property (
    $fell(devLow) |-> state_q.devCnt inside {[5'h0e:5'h11]})
    else $error("device low not one link clock");
  AST_DEV_RECOVERY: assert property (
    $fell(devLow) && state_q.inCycle |-> devHigh)
    else $error("no recovery high after sample");
  AST_DEV_TURN: assert property (
    $rose(devHigh) |-> devHigh[*8] ##[4:10] devOeN)
    else $error("recovery not released in turn clock");
  AST_DEV_SLOT: assert property (
    $rose(devLow) && state_q.inCycle |-> ##[0:2]
    (state_q.linkIdx % 3 == 2 && state_q.linkIdx < 96 &&
     USED_MASK[state_q.linkIdx / 3])) else $error("sample off slot");
  AST_DEV_HANDOFF: assert property (
    $fell(devLow) && !state_q.inCycle |-> ##[0:2] hostLow)
    else $error("host did not take over start");
  AST_START_WIDTH: assert property (
    $fell(hostLow) && !state_q.inCycle |->
    state_q.lineCnt inside {[8'h3c:8'h7f]}) else $error("start width");
  AST_STOP_WIDTH: assert property (
    $fell(hostLow) && state_q.inCycle |->
    state_q.hostCnt inside {[8'h1d:8'h21], [8'h2d:8'h31]})
    else $error("stop width");
  AST_HOST_END_HIGH: assert property (
    $fell(hostLow) |-> hostHigh) else $error("no high after low pulse");
  AST_HOST_RELEASE: assert property (
    $rose(hostHigh) |-> hostHigh[*8] ##[4:10] hostOeN)
    else $error("host high not released");

  COV_DEV_START: cover property ($fell(devLow) && !state_q.inCycle);
  COV_SAMPLE: cover property ($rose(devLow) && state_q.inCycle);
  COV_QUIET_STOP: cover property ($fell(hostLow) && state_q.inCycle &&
    state_q.hostCnt < 8'h28);
  COV_CONT_STOP: cover property ($fell(hostLow) && state_q.inCycle &&
    state_q.hostCnt >= 8'h28);
endmodule

// ===== sirq_dev.sv
// Contract
// - Line pulled low, driven high or released; link-clocked
// - Cycle is start, data frames, stop
// - Quiet start: device pulls low one clock
// - Host takes over start for 3-7 clocks
// - Host ends start high, then releases
// - Continuous start only by host, 4-8 clocks
// - After reset continuous, wait for host
// - Count frames from start pulse rising edge
// - Frame is sample, recovery, turn-around
// - Sample phase low when interrupt active
// - Recovery high, turn-around released
// - Drive from IRQ0 frame on clock rises
// - Frame f sampled at clock 3f-1
// - Frame to interrupt map, 32 frames
// - Host stops with 2 or 3 low clocks
// - Stop width picks next mode
// - Idle clocks may precede next start
`timescale 1ns/1ps
module sirq_dev #(
  parameter logic [31:0] USED_MASK = sirq_pkg::DEV_USED_MASK
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rstn,
  sirq_if.dev                                  link,
  input  wire logic [sirq_pkg::NUM_FRAMES-1:0] irqReq,
  output logic                                 quietMode,
  output logic                                 busy
);

  localparam int unsigned N = sirq_pkg::NUM_FRAMES;

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    logic                         clkMeta;  // Clock sync, stage one
    logic                         clkSync;  // Clock sync, stage two
    logic                         clkLast;  // For edge finding
    logic                         lineMeta; // Line sync, stage one
    logic                         lineSync; // Line sync, stage two
    sirq_pkg::sirq_dev_state_type state;    // Frame machine
    logic                         quiet;    // Next cycle quiet
    logic [1:0]                   phase;    // Phase within frame
    logic [sirq_pkg::FRAME_W-1:0] frame;    // Frame number, 1 based
    logic [2:0]                   lowRun;   // Low clocks in a row
    logic                         drove;    // Sample phase driven
    logic [N-1:0]                 reported; // Levels last reported
    logic                         driveOut; // Line drive level
    logic                         lineOeN;  // Drive enable, low on
    logic                         busy;     // Cycle in progress
  } sirq_dev_st_type;

  sirq_dev_st_type st_q;  // Registered state
  sirq_dev_st_type st_d;  // Next state

  // ----------------------------------------
  // Link helpers
  // ----------------------------------------
  logic rise;     // Link clock rising edge
  logic lineLow;  // Line level of the clock just ended
  logic pending;  // A used request changed

  // Edge from second and third stages only
  assign rise    = st_q.clkSync & ~st_q.clkLast;
  assign lineLow = ~st_q.lineSync;
  assign pending = |((irqReq ^ st_q.reported) & USED_MASK);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [1:0]                   ph;
    logic [sirq_pkg::FRAME_W-1:0] fr;
    logic [4:0]                   fi;
    logic                         hit;
    ph  = st_q.phase;
    fr  = st_q.frame;
    fi  = '0;
    hit = 1'b0;
    st_d = st_q;
    // Synchronisers for clock and line
    st_d.clkMeta  = link.hostBusClock;
    st_d.clkSync  = st_q.clkMeta;
    st_d.clkLast  = st_q.clkSync;
    st_d.lineMeta = link.serialLine;
    st_d.lineSync = st_q.lineMeta;
    // Phase and frame of the clock now beginning
    if (st_q.phase == sirq_pkg::PH_TURN) begin
      ph = sirq_pkg::PH_SAMPLE;
      if (st_q.frame != sirq_pkg::FRAME_SAT) begin
        fr = st_q.frame + 6'h01;
      end
    end else begin
      ph = st_q.phase + 2'h1;
    end
    fi  = fr[4:0] - sirq_pkg::FRAME_ONE;
    hit = (fr != '0) && (fr <= sirq_pkg::FRAME_MAX) &&
          USED_MASK[fi];
    // All line changes happen on link clock rises
    if (rise) begin
      unique case (st_q.state)
        // Waiting between cycles
        sirq_pkg::DEV_IDLE: begin
          st_d.lowRun  = '0;
          st_d.lineOeN = 1'b1;
          if (lineLow) begin
            // Host opened a start frame
            st_d.state = sirq_pkg::DEV_START;
          end else if (st_q.quiet && pending) begin
            // Open the start ourselves, one clock
            st_d.driveOut = 1'b0;
            st_d.lineOeN  = 1'b0;
            st_d.state    = sirq_pkg::DEV_START;
          end
        end
        // Start pulse in progress
        sirq_pkg::DEV_START: begin
          st_d.lineOeN = 1'b1;
          if (!lineLow) begin
            // Clock after the rise is turn-around
            st_d.state  = sirq_pkg::DEV_FRAMES;
            st_d.phase  = sirq_pkg::PH_TURN;
            st_d.frame  = '0;
            st_d.drove  = 1'b0;
            st_d.lowRun = '0;
          end
        end
        // Data frames, then watch for the stop pulse
        sirq_pkg::DEV_FRAMES: begin
          st_d.phase = ph;
          st_d.frame = fr;
          if (lineLow) begin
            // Count low clocks, saturating
            if (st_q.lowRun != sirq_pkg::RUN_SAT) begin
              st_d.lowRun = st_q.lowRun + 3'h1;
            end
          end else if (st_q.lowRun >= sirq_pkg::STOP_QUIET_CLKS) begin
            // A run of two or more can only be the stop
            st_d.quiet = (st_q.lowRun == sirq_pkg::STOP_QUIET_CLKS);
            st_d.state   = sirq_pkg::DEV_IDLE;
            st_d.lineOeN = 1'b1;
            st_d.drove   = 1'b0;
            st_d.lowRun  = '0;
          end else begin
            st_d.lowRun = '0;
          end
          // Drive our own frames only
          if (st_d.state == sirq_pkg::DEV_FRAMES) begin
            unique case (ph)
              sirq_pkg::PH_SAMPLE: begin
                st_d.drove   = 1'b0;
                st_d.lineOeN = 1'b1;
                if (hit) begin
                  st_d.reported[fi] = irqReq[fi];
                  if (irqReq[fi]) begin
                    st_d.driveOut = 1'b0;
                    st_d.lineOeN  = 1'b0;
                    st_d.drove    = 1'b1;
                  end
                end
              end
              sirq_pkg::PH_RECOV: begin
                if (st_q.drove) begin
                  st_d.driveOut = 1'b1;
                  st_d.lineOeN  = 1'b0;
                end
              end
              sirq_pkg::PH_TURN: begin
                st_d.lineOeN = 1'b1;
                st_d.drove   = 1'b0;
              end
              default: begin
                st_d.lineOeN = 1'b1;
              end
            endcase
          end
        end
        default: begin
          st_d.state   = sirq_pkg::DEV_IDLE;
          st_d.lineOeN = 1'b1;
        end
      endcase
    end
    // Busy follows the machine
    st_d.busy = (st_d.state != sirq_pkg::DEV_IDLE);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.quiet    <= sirq_pkg::RST_QUIET;
      st_q.lineOeN  <= sirq_pkg::RST_OE_N;
      st_q.driveOut <= sirq_pkg::RST_OUT;
      // Idle highs, so no false rise after reset
      st_q.clkMeta  <= sirq_pkg::RST_SYNC;
      st_q.clkSync  <= sirq_pkg::RST_SYNC;
      st_q.clkLast  <= sirq_pkg::RST_SYNC;
      st_q.lineMeta <= sirq_pkg::RST_SYNC;
      st_q.lineSync <= sirq_pkg::RST_SYNC;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------
  assign link.devOut  = st_q.driveOut;
  assign link.devOeN  = st_q.lineOeN;
  assign quietMode    = st_q.quiet;
  assign busy         = st_q.busy;

  // ----------------------------------------
  // Notes
  // ----------------------------------------
  // Drive changes lag the link rise by a few
  // system clocks; the line sampled at a rise
  // is the level of the clock just ended.
  // Own sample lows last one clock, so they
  // never pass for a stop pulse.
  // USED_MASK must stay inside the frames the
  // host really runs, else we drive into stop.

endmodule

// ===== sirq_host.sv
`timescale 1ns/1ps
module sirq_host #(
  parameter int unsigned START_CLKS = sirq_pkg::START_CLKS_DEF,
  parameter int unsigned EXTRA_CLKS = sirq_pkg::EXTRA_CLKS_DEF,
  parameter int unsigned FRAMES     = sirq_pkg::NUM_FRAMES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  sirq_if.host                            link,
  input  wire logic                       cycleReq,
  input  wire logic                       quietReq,
  output logic [sirq_pkg::NUM_FRAMES-1:0] irqState,
  output logic                            quietMode,
  output logic                            cycleDone
);

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    logic                          clkMeta;  // Clock sync one
    logic                          clkSync;  // Clock sync two
    logic                          clkLast;  // Edge finding
    logic                          lineMeta; // Line sync one
    logic                          lineSync; // Line sync two
    sirq_pkg::sirq_host_state_type state;    // Cycle machine
    logic [3:0]                    cnt;      // Pulse clocks left
    logic [1:0]                    phase;    // Frame phase
    logic [5:0]                    frame;    // Frame, 1 based
    logic [sirq_pkg::NUM_FRAMES-1:0] irq;    // Sampled requests
    logic                          quiet;    // Mode announced
    logic                          done;     // Cycle end pulse
    logic                          driveOut; // Drive level
    logic                          lineOeN;  // Enable, low on
  } sirq_host_st_type;

  sirq_host_st_type st_q;  // Registered state
  sirq_host_st_type st_d;  // Next state

  logic rise;    // Link clock rising edge
  logic lineLow; // Level of clock just ended

  assign rise    = st_q.clkSync & ~st_q.clkLast;
  assign lineLow = ~st_q.lineSync;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [5:0] fi;
    fi   = st_q.frame - 6'h01;
    st_d = st_q;
    st_d.clkMeta  = link.hostBusClock;
    st_d.clkSync  = st_q.clkMeta;
    st_d.clkLast  = st_q.clkSync;
    st_d.lineMeta = link.serialLine;
    st_d.lineSync = st_q.lineMeta;
    st_d.done     = 1'b0;
    if (rise) begin
      unique case (st_q.state)
        // Idle: device start or own request
        sirq_pkg::HST_IDLE: begin
          st_d.lineOeN = 1'b1;
          if (lineLow) begin
            st_d.driveOut = 1'b0;
            st_d.lineOeN  = 1'b0;
            st_d.cnt      = 4'(EXTRA_CLKS - 1);
            st_d.state    = sirq_pkg::HST_START;
          end else if (cycleReq) begin
            st_d.driveOut = 1'b0;
            st_d.lineOeN  = 1'b0;
            st_d.cnt      = 4'(START_CLKS - 1);
            st_d.state    = sirq_pkg::HST_START;
          end
        end
        // Holding the start low
        sirq_pkg::HST_START: begin
          if (st_q.cnt == 4'h0) begin
            st_d.driveOut = 1'b1;
            st_d.state    = sirq_pkg::HST_HIGH;
          end else begin
            st_d.cnt = st_q.cnt - 4'h1;
          end
        end
        // High clock over, release to frames
        sirq_pkg::HST_HIGH: begin
          st_d.lineOeN = 1'b1;
          st_d.phase   = sirq_pkg::PH_TURN;
          st_d.frame   = '0;
          st_d.state   = sirq_pkg::HST_FRAMES;
        end
        // Walk the frames, capture samples
        sirq_pkg::HST_FRAMES: begin
          if (st_q.phase == sirq_pkg::PH_TURN) begin
            if (st_q.frame == 6'(FRAMES)) begin
              st_d.driveOut = 1'b0;
              st_d.lineOeN  = 1'b0;
              st_d.quiet    = quietReq;
              st_d.cnt      = quietReq ?
                4'(sirq_pkg::STOP_QUIET_CLKS - 3'h1) :
                4'(sirq_pkg::STOP_CONT_CLKS - 3'h1);
              st_d.state    = sirq_pkg::HST_STOP;
            end else begin
              st_d.phase = sirq_pkg::PH_SAMPLE;
              st_d.frame = st_q.frame + 6'h01;
            end
          end else begin
            st_d.phase = st_q.phase + 2'h1;
            if (st_q.phase == sirq_pkg::PH_SAMPLE) begin
              st_d.irq[fi[4:0]] = lineLow;
            end
          end
        end
        // Holding the stop low
        sirq_pkg::HST_STOP: begin
          if (st_q.cnt == 4'h0) begin
            st_d.driveOut = 1'b1;
            st_d.state    = sirq_pkg::HST_SHIGH;
          end else begin
            st_d.cnt = st_q.cnt - 4'h1;
          end
        end
        // Turn-around after stop
        sirq_pkg::HST_SHIGH: begin
          st_d.lineOeN = 1'b1;
          st_d.done    = 1'b1;
          st_d.state   = sirq_pkg::HST_IDLE;
        end
        default: begin
          st_d.state   = sirq_pkg::HST_IDLE;
          st_d.lineOeN = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.quiet    <= sirq_pkg::RST_QUIET;
      st_q.lineOeN  <= sirq_pkg::RST_OE_N;
      st_q.driveOut <= sirq_pkg::RST_OUT;
      // Idle highs, so no false rise after reset
      st_q.clkMeta  <= sirq_pkg::RST_SYNC;
      st_q.clkSync  <= sirq_pkg::RST_SYNC;
      st_q.clkLast  <= sirq_pkg::RST_SYNC;
      st_q.lineMeta <= sirq_pkg::RST_SYNC;
      st_q.lineSync <= sirq_pkg::RST_SYNC;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs, straight from flops
  assign link.hostOut  = st_q.driveOut;
  assign link.hostOeN  = st_q.lineOeN;
  assign irqState      = st_q.irq;
  assign quietMode     = st_q.quiet;
  assign cycleDone     = st_q.done;

endmodule

// ===== sirq_if.sv
`timescale 1ns/1ps
interface sirq_if;

  // ----------------------------------------
  // Link signals
  // ----------------------------------------
  logic hostBusClock; // Link clock, made by the bench
  logic devOut;       // Device drive level
  logic devOeN;       // Device drive enable, low drives
  logic hostOut;      // Host drive level
  logic hostOeN;      // Host drive enable, low drives
  logic serialLine;   // Resolved shared line

  // Wired line: any low wins, pulled up when released
  assign serialLine = !((!devOeN && !devOut) ||
                        (!hostOeN && !hostOut));

  // Documented device end
  modport dev (
    input  hostBusClock,
    input  serialLine,
    output devOut,
    output devOeN
  );

  // Host controller end
  modport host (
    input  hostBusClock,
    input  serialLine,
    output hostOut,
    output hostOeN
  );

endinterface

// ===== sirq_pkg.sv
package sirq_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int unsigned NUM_FRAMES = 32;    // Frames in a full cycle
  localparam int unsigned FRAME_W    = 6;     // Width of frame counter
  localparam logic [5:0]  FRAME_SAT  = 6'h3f; // Counter saturation
  localparam logic [5:0]  FRAME_MAX  = 6'h20; // Last legal frame
  localparam logic [4:0]  FRAME_ONE  = 5'h01; // Frame to index offset

  // Phases of one three clock frame
  localparam logic [1:0]  PH_SAMPLE  = 2'h0;  // Sample clock
  localparam logic [1:0]  PH_RECOV   = 2'h1;  // Recovery clock
  localparam logic [1:0]  PH_TURN    = 2'h2;  // Turn-around clock

  // ----------------------------------------
  // Pulse widths in link clocks
  // ----------------------------------------
  localparam logic [2:0]  STOP_QUIET_CLKS = 3'h2; // Stop low, next quiet
  localparam logic [2:0]  STOP_CONT_CLKS  = 3'h3; // Stop low, next cont.
  localparam logic [2:0]  RUN_SAT         = 3'h7; // Low run saturation
  localparam int unsigned START_CLKS_DEF  = 4;    // Host start, 4 to 8
  localparam int unsigned EXTRA_CLKS_DEF  = 3;    // Host takeover, 3 to 7

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic        RST_QUIET  = 1'b0;  // Continuous after reset
  localparam logic        RST_OE_N   = 1'b1;  // Line released
  localparam logic        RST_OUT    = 1'b1;  // Idle drive level high
  localparam logic        RST_SYNC   = 1'b1;  // Sync flops start idle high

  // Frames the device reports: IRQ1,3,4,6,7,12
  localparam logic [31:0] DEV_USED_MASK = 32'h000010da;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_START,
    DEV_FRAMES
  } sirq_dev_state_type;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_START,
    HST_HIGH,
    HST_FRAMES,
    HST_STOP,
    HST_SHIGH
  } sirq_host_state_type;

endpackage

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk_sys   = 1'b0;  // System clock
  logic        rstn      = 1'b0;  // Reset, active low
  logic        linkClk   = 1'b0;  // Link clock
  logic [31:0] irqReq    = 32'h0; // Device requests
  logic        cycleReq  = 1'b0;  // Host cycle request
  logic        quietReq  = 1'b0;  // Host stop width pick
  logic        badOut    = 1'b1;  // Fault host drive level
  logic        badOeN    = 1'b1;  // Fault host enable
  logic        watchIdle = 1'b0;  // Count line lows
  logic [31:0] irqState;          // Host frame samples
  logic        devQuiet;          // Device mode
  logic        hostQuiet;         // Host mode
  logic        badQuiet;          // Fault pair device mode
  logic        busy;              // Device busy
  logic        cycleDone;         // Host cycle end
  int          failures  = 0;
  int          tests_run = 0;
  int          idleLows  = 0;

  sirq_if sirqLink ();
  sirq_if sirqBad ();
  assign sirqLink.hostBusClock = linkClk;
  assign sirqBad.hostBusClock  = linkClk;
  assign sirqBad.hostOut       = badOut;
  assign sirqBad.hostOeN       = badOeN;

  always #4 clk_sys = ~clk_sys;
  always #62.5 linkClk = ~linkClk;

  sirq_dev sirq_dev_inst (.clk_sys(clk_sys), .rstn(rstn),
    .link(sirqLink), .irqReq(irqReq), .quietMode(devQuiet), .busy(busy));
  sirq_host sirq_host_inst (.clk_sys(clk_sys), .rstn(rstn),
    .link(sirqLink), .cycleReq(cycleReq), .quietReq(quietReq),
    .irqState(irqState), .quietMode(hostQuiet), .cycleDone(cycleDone));
  sirq_dev sirq_dev_fault_inst (.clk_sys(clk_sys), .rstn(rstn),
    .link(sirqBad), .irqReq(32'h0), .quietMode(badQuiet), .busy());
  sirq_checker #(.USED_MASK(sirq_pkg::DEV_USED_MASK)) sirq_checker_inst (
    .clk_sys(clk_sys), .rstn(rstn), .hostBusClock(sirqLink.hostBusClock),
    .devOut(sirqLink.devOut), .devOeN(sirqLink.devOeN),
    .hostOut(sirqLink.hostOut), .hostOeN(sirqLink.hostOeN),
    .serialLine(sirqLink.serialLine));

  // Counts line lows while the link should stay quiet
  always @(posedge clk_sys) begin
    if (watchIdle && sirqLink.serialLine !== 1'b1) begin
      idleLows++;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return busy;
      1: return cycleDone;
      default: return sirqLink.serialLine;
    endcase
  endfunction

  // Bounded wait for busy, done or line level
  task automatic waitSig(input int sel, input logic lvl, input int limit);
    int n;
    n = 0;
    while (pick(sel) !== lvl && n < limit) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(32'(n < limit), 32'h1);
  endtask

  // Host cycle on request, with chosen stop width
  task automatic hostCycle(input logic quiet);
    @(posedge clk_sys);
    cycleReq <= 1'b1;
    quietReq <= quiet;
    waitSig(2, 1'b0, 400);
    @(posedge clk_sys);
    cycleReq <= 1'b0;
    waitSig(1, 1'b1, 4000);
  endtask

  // Quiet period of 20 link clocks, counts line lows
  task automatic quietSpan();
    @(posedge clk_sys);
    idleLows = 0;
    watchIdle <= 1'b1;
    repeat (320) @(posedge clk_sys);
    watchIdle <= 1'b0;
  endtask

  // Fault host: low pulse, one high clock, release
  task automatic badPulse(input int lowClks);
    repeat (lowClks) begin
      @(posedge linkClk);
      @(posedge clk_sys);
      badOut <= 1'b0;
      badOeN <= 1'b0;
    end
    @(posedge linkClk);
    @(posedge clk_sys);
    badOut <= 1'b1;
    @(posedge linkClk);
    @(posedge clk_sys);
    badOeN <= 1'b1;
  endtask

  task automatic badCycle(input int stopClks);
    badPulse(4);
    repeat (96) @(posedge linkClk);
    badPulse(stopClks);
    repeat (2) @(posedge linkClk);
    repeat (4) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    irqReq <= 32'h8000_00d6;
    quietSpan();
    check(32'(idleLows), 32'h0);
    check(32'(devQuiet), 32'h0);
    hostCycle(1'b0);
    check(irqState, 32'h0000_00d2);
    check(32'(devQuiet), 32'h0);
    hostCycle(1'b1);
    check(32'(devQuiet), 32'h1);
    check(32'(hostQuiet), 32'h1);
    quietSpan();
    check(32'(idleLows), 32'h0);
    irqReq <= 32'h0000_1048;
    waitSig(0, 1'b1, 200);
    waitSig(1, 1'b1, 4000);
    check(irqState, 32'h0000_1048);
    check(32'(devQuiet), 32'h1);
    hostCycle(1'b0);
    check(32'(devQuiet), 32'h0);
    @(posedge clk_sys);
    irqReq <= 32'h0;
    quietSpan();
    check(32'(idleLows), 32'h0);
    check(32'(busy), 32'h0);
    badCycle(2);
    check(32'(badQuiet), 32'h1);
    badCycle(4);
    check(32'(badQuiet), 32'h0);
    complete_run();
  end

  // Watchdog on a hung handshake
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
